// ===== design/spi_link_shift.sv
// Serial-clock side: shifts commands in and answers reads on the data out
`timescale 1ns/10ps
`include "switch_bank_map.svh"
module spi_link_shift
   import switch_bank_pkg::*;
(
   input wire logic sclk,
   input wire logic rst,
   input wire logic cs_n,
   input wire logic sdi,
   input wire logic crc_en,
   input wire logic [31:0] image,
   output logic sdo,
   output logic [23:0] cmd_word,
   output logic cmd_toggle,
   output logic [4:0] resid,
   output logic [1:0] cmd_count
);

   link_state_t q;
   link_state_t d;
   logic started_q;
   logic sdo_q;
   logic frame_rst;
   logic [4:0] cur;
   logic [4:0] nxt;
   logic [4:0] len;
   logic [1:0] ncur;
   logic [7:0] rd_byte;
   logic [7:0] align;
   logic tx_bit;

   assign frame_rst = rst | cs_n;

   always_comb
   begin
      d = q;
      align = `ALIGN_BYTE;
      // First edge of a frame restarts both counts
      cur = started_q ? q.cnt : 5'h00;
      ncur = started_q ? q.ncmd : 2'h0;
      nxt = cur + 5'h01;
      len = crc_en ? `LEN_CRC : `LEN_PLAIN;
      d.shift = {q.shift[22:0], sdi};
      d.ncmd = ncur;
      d.cnt = nxt;
      if (nxt == `HDR_BITS)
         d.hdr = d.shift[7:0];
      if (nxt == len)
      begin
         d.cnt = 5'h00;
         d.cmd = d.shift;
         d.tog = ~q.tog;
         if (ncur != 2'h3)
            d.ncmd = ncur + 2'h1;
      end
      unique case (q.hdr[6:0])
         `ADDR_SWITCH: rd_byte = image[7:0];
         `ADDR_CONFIG: rd_byte = image[15:8];
         `ADDR_FLAGS: rd_byte = image[23:16];
         `ADDR_BURST: rd_byte = image[31:24];
         default: rd_byte = 8'h00;
      endcase
      if (!q.hdr[`HDR_RD_BIT])
         rd_byte = 8'h00;
      if (q.cnt < `HDR_BITS)
         tx_bit = align[~q.cnt[2:0]];
      else if (q.cnt < `LEN_PLAIN)
         tx_bit = rd_byte[~q.cnt[2:0]];
      else
         tx_bit = 1'h0;
   end

   always_ff @(posedge sclk or posedge rst)
   begin
      if (rst)
         q <= '0;
      else
         q <= d;
   end

   always_ff @(posedge sclk or posedge frame_rst)
   begin
      if (frame_rst)
         started_q <= 1'h0;
      else
         started_q <= 1'h1;
   end

   // Data out changes on the falling edge
   always_ff @(negedge sclk or posedge frame_rst)
   begin
      if (frame_rst)
         sdo_q <= 1'h0;
      else
         sdo_q <= tx_bit;
   end

   assign sdo = sdo_q;
   assign cmd_word = q.cmd;
   assign cmd_toggle = q.tog;
   assign resid = q.cnt;
   assign cmd_count = q.ncmd;

endmodule : spi_link_shift

// ===== design/spi_switch_register_bank.sv
// Register bank of an octal switch behind a serial target port
`timescale 1ns/10ps
`include "switch_bank_map.svh"
// Notes on behaviour
// - switch register at 0x01, resets 0x00
// - config register at 0x02, resets 0x06
// - config bit 2 enables bad address check
// - config bit 1 enables clock count check
// - no CRC, no burst: exactly 16 clocks
// - CRC, no burst: exactly 24 clocks
// - burst, no CRC: any multiple of 16
// - config bit 0 enables CRC check, off
// - CRC on makes every command 24 bits
// - errors set address, clock and CRC flags
// - command 0x6CA9 or the key pair clears the flags
// - burst bit allows many commands per frame
// - keys A3 then 05 restore all defaults
module spi_switch_register_bank
   import switch_bank_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic sdi,
   output logic sdo,
   output logic [7:0] switch_enables,
   output logic [7:0] error_status_flags
);

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   bank_state_t q;
   bank_state_t d;
   logic [23:0] link_cmd;
   logic link_tog;
   logic [4:0] link_resid;
   logic [1:0] link_count;
   logic tog_s;
   logic cs_s;
   logic new_cmd;
   logic crc_on;
   logic burst_on;
   logic [15:0] word;
   logic crc_bad;
   logic count_bad;
   logic do_cmd;
   logic [15:0] cmd;
   logic clear_req;
   logic soft_req;
   logic addr_bad;
   logic [7:0] set_flags;
   logic [15:0] pend_n;
   logic pend_vn;

   // ------------------------------------------------------------
   // CRC over one 16-bit command, MSB first
   // ------------------------------------------------------------
   function automatic logic [7:0] crc8(input logic [15:0] w);
      logic [7:0] c;
      c = `CRC_INIT;
      for (int i = 15; i >= 0; i--)
      begin
         if (c[7] ^ w[i])
            c = {c[6:0], 1'h0} ^ `CRC_POLY;
         else
            c = {c[6:0], 1'h0};
      end
      return c;
   endfunction : crc8

   // ------------------------------------------------------------
   // Link side and crossings
   // ------------------------------------------------------------
   spi_link_shift link
   (
      .sclk(sclk),
      .rst(rst),
      .cs_n(cs_n),
      .sdi(sdi),
      .crc_en(q.cfg[`BIT_CRC_EN]),
      .image({q.burst, q.flags, q.cfg, q.sw}),
      .sdo(sdo),
      .cmd_word(link_cmd),
      .cmd_toggle(link_tog),
      .resid(link_resid),
      .cmd_count(link_count)
   );

   sync_two_flop #(.RESET_VAL(1'h0)) tog_sync
   (
      .clock(clock),
      .rst(rst),
      .din(link_tog),
      .dout(tog_s)
   );

   sync_two_flop #(.RESET_VAL(1'h1)) cs_sync
   (
      .clock(clock),
      .rst(rst),
      .din(cs_n),
      .dout(cs_s)
   );

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb
   begin
      d = q;
      d.tog_seen = tog_s;
      new_cmd = tog_s ^ q.tog_seen;
      crc_on = q.cfg[`BIT_CRC_EN];
      burst_on = q.burst[`BIT_BURST];
      // Command word sits above the CRC byte when CRC is on
      word = crc_on ? link_cmd[23:8] : link_cmd[15:0];
      crc_bad = crc_on && (crc8(word) != link_cmd[7:0]);
      count_bad = 1'h0;
      set_flags = 8'h00;
      do_cmd = 1'h0;
      cmd = 16'h0000;
      clear_req = 1'h0;
      soft_req = 1'h0;
      addr_bad = 1'h0;
      pend_n = q.pend;
      pend_vn = q.pend_v;

      // A finished command: check CRC, then run or hold it
      if (new_cmd)
      begin
         if (crc_bad)
            set_flags[`FLAG_CRC] = 1'h1;
         else if (burst_on)
         begin
            do_cmd = 1'h1;
            cmd = word;
         end
         else if (!q.pend_v)
         begin
            pend_n = word;
            pend_vn = 1'h1;
         end
      end

      unique case (q.phase)
         PH_IDLE:
         begin
            pend_vn = 1'h0;
            if (!cs_s)
               d.phase = PH_FRAME;
         end
         PH_FRAME:
         begin
            if (cs_s)
               d.phase = PH_END;
         end
         PH_END:
         begin
            // Whole commands only; one command unless burst is on
            count_bad = (link_resid != 5'h00) ||
               (!burst_on && (link_count > 2'h1));
            if (q.cfg[`BIT_CLK_EN] && count_bad)
               set_flags[`FLAG_CLK] = 1'h1;
            else if (pend_vn && !do_cmd)
            begin
               do_cmd = 1'h1;
               cmd = pend_n;
            end
            pend_vn = 1'h0;
            d.phase = PH_IDLE;
         end
         default:
         begin
            pend_vn = 1'h0;
            d.phase = PH_IDLE;
         end
      endcase
      d.pend = pend_n;
      d.pend_v = pend_vn;

      // Execute one command
      if (do_cmd)
      begin
         d.armed = 1'h0;
         if (cmd == `CLEAR_CMD)
            clear_req = 1'h1;
         else if (cmd[`CMD_RD_BIT])
         begin
            unique case (cmd[14:8])
               `ADDR_SWITCH, `ADDR_CONFIG, `ADDR_FLAGS,
               `ADDR_BURST, `ADDR_SWRESET: addr_bad = 1'h0;
               default: addr_bad = 1'h1;
            endcase
         end
         else
         begin
            unique case (cmd[14:8])
               `ADDR_SWITCH: d.sw = cmd[7:0];
               `ADDR_CONFIG: d.cfg = cmd[7:0] & `CFG_MASK;
               `ADDR_BURST: d.burst = cmd[7:0] & `BURST_MASK;
               `ADDR_SWRESET:
               begin
                  if (cmd[7:0] == `KEY_FIRST)
                     d.armed = 1'h1;
                  else if (q.armed && (cmd[7:0] == `KEY_SECOND))
                     soft_req = 1'h1;
               end
               default: addr_bad = 1'h1;
            endcase
         end
         if (addr_bad && q.cfg[`BIT_ADDR_EN])
            set_flags[`FLAG_ADDR] = 1'h1;
      end

      // A flag set in the clearing cycle survives
      d.flags = (clear_req ? `RST_FLAGS : q.flags) | set_flags;

      if (soft_req)
      begin
         d.sw = `RST_SWITCH;
         d.cfg = `RST_CONFIG;
         d.flags = `RST_FLAGS;
         d.burst = `RST_BURST;
         d.armed = 1'h0;
      end
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         q <= '0;
         q.phase <= PH_IDLE;
         q.sw <= `RST_SWITCH;
         q.cfg <= `RST_CONFIG;
         q.flags <= `RST_FLAGS;
         q.burst <= `RST_BURST;
      end
      else
         q <= d;
   end

   assign switch_enables = q.sw;
   assign error_status_flags = q.flags;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);

   sequence key_first_s;
      do_cmd && !cmd[`CMD_RD_BIT] && (cmd[14:8] == `ADDR_SWRESET)
         && (cmd[7:0] == `KEY_FIRST);
   endsequence

   sequence key_second_s;
      do_cmd && !cmd[`CMD_RD_BIT] && (cmd[14:8] == `ADDR_SWRESET)
         && (cmd[7:0] == `KEY_SECOND);
   endsequence

   sequence sw_write_s;
      do_cmd && !cmd[`CMD_RD_BIT] && (cmd[14:8] == `ADDR_SWITCH)
         && !soft_req;
   endsequence

   sw_write_a: assert property (
      sw_write_s |=> (switch_enables == $past(cmd[7:0])))
      else $error("switch write not stored");

   cfg_default_a: assert property (
      (q.armed and key_second_s) |=> (q.cfg == `RST_CONFIG))
      else $error("config not at default after key pair");

   cfg_reserved_a: assert property (
      (do_cmd && !cmd[`CMD_RD_BIT] && (cmd[14:8] == `ADDR_CONFIG))
         |=> (q.cfg == ($past(cmd[7:0]) & `CFG_MASK)))
      else $error("config write or reserved bits wrong");

   addr_err_a: assert property (
      (do_cmd && q.cfg[`BIT_ADDR_EN] && !cmd[`CMD_RD_BIT]
         && (cmd[14:8] == `ADDR_FLAGS) && !soft_req)
         |=> error_status_flags[`FLAG_ADDR])
      else $error("write to read-only address not flagged");

   addr_off_a: assert property (
      (do_cmd && !q.cfg[`BIT_ADDR_EN] && !error_status_flags[`FLAG_ADDR])
         |=> !error_status_flags[`FLAG_ADDR])
      else $error("address flag set while check is off");

   clk_off_a: assert property (
      ((q.phase == PH_END) && !q.cfg[`BIT_CLK_EN]
         && !error_status_flags[`FLAG_CLK])
         |=> !error_status_flags[`FLAG_CLK])
      else $error("clock flag set while check is off");

   len_plain_a: assert property (
      ((q.phase == PH_END) && q.cfg[`BIT_CLK_EN] && !crc_on && !burst_on
         && (link_resid != 5'h00)) |=> error_status_flags[`FLAG_CLK])
      else $error("short plain frame not flagged");

   len_crc_a: assert property (
      ((q.phase == PH_END) && q.cfg[`BIT_CLK_EN] && crc_on && !burst_on
         && ((link_resid != 5'h00) || (link_count > 2'h1)))
         |=> error_status_flags[`FLAG_CLK])
      else $error("long CRC frame not flagged");

   burst_plain_a: assert property (
      ((q.phase == PH_END) && burst_on && !crc_on
         && (link_resid == 5'h00) && !do_cmd && !new_cmd)
         |=> $stable(error_status_flags[`FLAG_CLK]))
      else $error("good burst frame flagged");

   burst_crc_a: assert property (
      ((q.phase == PH_END) && burst_on && crc_on
         && (link_resid == 5'h00) && !do_cmd && !new_cmd)
         |=> $stable(error_status_flags[`FLAG_CLK]))
      else $error("good CRC burst frame flagged");

   crc_err_a: assert property (
      (new_cmd && crc_on && crc_bad) |=> error_status_flags[`FLAG_CRC])
      else $error("bad CRC not flagged");

   crc_drop_a: assert property (
      (new_cmd && crc_bad && burst_on) |-> !do_cmd ##1 $stable(q.sw))
      else $error("command with bad CRC executed");

   flags_hold_a: assert property (
      (!clear_req && !soft_req)
         |=> ((q.flags & $past(q.flags)) == $past(q.flags)))
      else $error("flag dropped without clear command");

   clear_set_a: assert property (
      (clear_req && set_flags[`FLAG_CRC]) |=> error_status_flags[`FLAG_CRC])
      else $error("flag event lost in clearing cycle");

   burst_exec_a: assert property (
      (new_cmd && burst_on && !crc_bad) |-> do_cmd)
      else $error("burst command not executed");

   key_arm_a: assert property (
      (key_first_s and (!soft_req)) |=> q.armed)
      else $error("first key did not arm reset");

   soft_reset_a: assert property (
      (q.armed and key_second_s) |=> ((switch_enables == `RST_SWITCH)
         && (q.burst == `RST_BURST) && (error_status_flags == `RST_FLAGS)))
      else $error("key pair did not restore defaults");

   reserved_zero_a: assert property (
      (do_cmd && !cmd[`CMD_RD_BIT] && (cmd[14:8] == `ADDR_BURST))
         |=> (q.burst[7:1] == 7'h00) ##1 (q.cfg[7:3] == 5'h00))
      else $error("reserved bits not zero");

endmodule : spi_switch_register_bank

// ===== design/sync_two_flop.sv
// Two flip-flop synchroniser for one level
`timescale 1ns/10ps
`include "switch_bank_map.svh"
module sync_two_flop
   import switch_bank_pkg::*;
#(
   parameter logic RESET_VAL = 1'h0
)
(
   input wire logic clock,
   input wire logic rst,
   input wire logic din,
   output logic dout
);

   sync_state_t q;
   sync_state_t d;

   always_comb
   begin
      d.meta = din;
      d.stable = q.meta;
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         q <= {RESET_VAL, RESET_VAL};
      else
         q <= d;
   end

   assign dout = q.stable;

endmodule : sync_two_flop

// ===== inc/switch_bank_map.svh
// Register map, field positions, reset values and frame constants
`ifndef SWITCH_BANK_MAP_SVH
`define SWITCH_BANK_MAP_SVH

// ----------------------------------------------------------------
// Register addresses (7-bit address field of a command)
// ----------------------------------------------------------------
`define ADDR_SWITCH 7'h01
`define ADDR_CONFIG 7'h02
`define ADDR_FLAGS 7'h03
`define ADDR_BURST 7'h05
`define ADDR_SWRESET 7'h0B

// ----------------------------------------------------------------
// Reset values and writable masks
// ----------------------------------------------------------------
`define RST_SWITCH 8'h00
`define RST_CONFIG 8'h06
`define RST_FLAGS 8'h00
`define RST_BURST 8'h00
`define CFG_MASK 8'h07
`define BURST_MASK 8'h01

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BIT_ADDR_EN 2
`define BIT_CLK_EN 1
`define BIT_CRC_EN 0
`define BIT_BURST 0
`define FLAG_ADDR 2
`define FLAG_CLK 1
`define FLAG_CRC 0
`define CMD_RD_BIT 15
`define HDR_RD_BIT 7

// ----------------------------------------------------------------
// Frame constants and special values
// ----------------------------------------------------------------
`define LEN_PLAIN 5'h10
`define LEN_CRC 5'h18
`define HDR_BITS 5'h08
`define CLEAR_CMD 16'h6CA9
`define KEY_FIRST 8'hA3
`define KEY_SECOND 8'h05
`define ALIGN_BYTE 8'h25
`define CRC_POLY 8'h07
`define CRC_INIT 8'h00

`endif

// ===== inc/switch_bank_pkg.sv
// Types shared by the switch register bank and its link logic
package switch_bank_pkg;

   typedef enum logic [2:0]
   {
      PH_IDLE = 3'h1,
      PH_FRAME = 3'h2,
      PH_END = 3'h4
   } phase_t;

   typedef struct packed
   {
      logic meta;
      logic stable;
   } sync_state_t;

   typedef struct packed
   {
      logic [23:0] shift;
      logic [4:0] cnt;
      logic [1:0] ncmd;
      logic [7:0] hdr;
      logic [23:0] cmd;
      logic tog;
   } link_state_t;

   typedef struct packed
   {
      phase_t phase;
      logic [7:0] sw;
      logic [7:0] cfg;
      logic [7:0] flags;
      logic [7:0] burst;
      logic armed;
      logic tog_seen;
      logic [15:0] pend;
      logic pend_v;
   } bank_state_t;

endpackage : switch_bank_pkg

// ===== verification/spi_ctrl_model.sv
// Serial controller model that drives frames into the switch bank
`timescale 1ns/10ps
module spi_ctrl_model
(
   output logic sclk,
   output logic cs_n,
   output logic sdi,
   input wire logic sdo
);
   logic [23:0] rx;

   initial
   begin
      sclk = 1'h0;
      cs_n = 1'h1;
      sdi = 1'h0;
      rx = 24'h000000;
   end

   // ----------------------------------------------------------------
   // One frame, MSB first; the clock rests low outside frames
   // ----------------------------------------------------------------
   task automatic frame(input logic [71:0] bits, input int n);
      int i;
      cs_n = 1'h0;
      #16;
      for (i = n - 1; i >= 0; i--)
      begin
         sdi = bits[i];
         #16;
         sclk = 1'h1;
         rx = {rx[22:0], sdo};
         #16;
         sclk = 1'h0;
      end
      #16;
      cs_n = 1'h1;
      // Released line shows no stale level
      sdi = ~sdi;
   endtask : frame
endmodule : spi_ctrl_model

// ===== verification/tb_spi_switch_register_bank.sv
// Self-checking bench for the switch register bank
`timescale 1ns/10ps
`include "switch_bank_map.svh"
module tb_spi_switch_register_bank;
   import switch_bank_pkg::*;
   logic clock;
   logic rst;
   logic sclk;
   logic cs_n;
   logic sdi;
   logic sdo;
   logic [7:0] sw;
   logic [7:0] fl;
   int errors;
   int cmp_count;

   spi_switch_register_bank uut
   (
      .clock(clock),
      .rst(rst),
      .sclk(sclk),
      .cs_n(cs_n),
      .sdi(sdi),
      .sdo(sdo),
      .switch_enables(sw),
      .error_status_flags(fl)
   );

   spi_ctrl_model m
   (
      .sclk(sclk),
      .cs_n(cs_n),
      .sdi(sdi),
      .sdo(sdo)
   );

   initial
   begin
      clock = 1'h0;
      rst = 1'h1;
      errors = 0;
      cmp_count = 0;
   end

   always #12.5 clock = ~clock;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic cmp8(input string what, input logic [7:0] exp,
      input logic [7:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp8

   function automatic logic [7:0] crc8(input logic [15:0] w);
      logic [7:0] c;
      int i;
      c = 8'h00;
      for (i = 15; i >= 0; i--)
         c = (c[7] ^ w[i]) ? ({c[6:0], 1'h0} ^ 8'h07) : {c[6:0], 1'h0};
      return c;
   endfunction : crc8

   function automatic logic [23:0] c24(input logic [6:0] a,
      input logic [7:0] d);
      return {1'h0, a, d, crc8({1'h0, a, d})};
   endfunction : c24

   task automatic send(input logic [71:0] b, input int n);
      m.frame(b, n);
      repeat (10) @(posedge clock);
   endtask : send

   // Single command; n is 16, 17 or 24 clocks; bad spoils the CRC
   // A 17-clock frame carries one surplus clock after the command
   task automatic xfer(input logic [6:0] a, input logic [7:0] d,
      input logic r, input int n, input logic bad);
      logic [15:0] w;
      w = {r, a, d};
      if (n == 24)
         send({48'h0, w, crc8(w) ^ {7'h00, bad}}, 24);
      else if (n == 17)
         send({55'h0, w, 1'h0}, 17);
      else
         send({56'h0, w}, n);
   endtask : xfer

   task automatic rd(input logic [6:0] a, input int n, output logic [7:0] d);
      xfer(a, 8'h00, 1'h1, n, 1'h0);
      d = (n == 24) ? m.rx[15:8] : m.rx[7:0];
   endtask : rd

   task automatic done(input string name);
      $display("test %s done", name);
   endtask : done

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset;
      logic [7:0] d;
      cmp8("switches", 8'h00, sw);
      cmp8("flags", 8'h00, fl);
      rd(`ADDR_CONFIG, 16, d);
      cmp8("config", 8'h06, d);
      cmp8("align", 8'h25, m.rx[15:8]);
      done("reset");
   endtask : t_reset

   task automatic t_regs;
      logic [7:0] d;
      xfer(`ADDR_SWITCH, 8'h5A, 1'h0, 16, 1'h0);
      cmp8("switches", 8'h5A, sw);
      rd(`ADDR_SWITCH, 16, d);
      cmp8("switch rd", 8'h5A, d);
      xfer(`ADDR_CONFIG, 8'h02, 1'h0, 16, 1'h0);
      rd(`ADDR_CONFIG, 16, d);
      cmp8("config rd", 8'h02, d);
      xfer(`ADDR_CONFIG, 8'h06, 1'h0, 16, 1'h0);
      xfer(`ADDR_BURST, 8'hFE, 1'h0, 16, 1'h0);
      rd(`ADDR_BURST, 16, d);
      cmp8("burst rd", 8'h00, d);
      done("regs");
   endtask : t_regs

   task automatic t_addr;
      logic [7:0] d;
      rd(7'h04, 16, d);
      cmp8("flags", 8'h04, fl);
      xfer(7'h6C, 8'hA9, 1'h0, 16, 1'h0);
      cmp8("flags", 8'h00, fl);
      xfer(`ADDR_FLAGS, 8'h11, 1'h0, 16, 1'h0);
      cmp8("flags", 8'h04, fl);
      xfer(7'h6C, 8'hA9, 1'h0, 16, 1'h0);
      xfer(`ADDR_CONFIG, 8'h02, 1'h0, 16, 1'h0);
      xfer(7'h04, 8'h11, 1'h0, 16, 1'h0);
      cmp8("flags", 8'h00, fl);
      xfer(`ADDR_CONFIG, 8'h06, 1'h0, 16, 1'h0);
      done("addr");
   endtask : t_addr

   task automatic t_count;
      xfer(`ADDR_SWITCH, 8'h33, 1'h0, 17, 1'h0);
      cmp8("flags", 8'h02, fl);
      cmp8("switches", 8'h5A, sw);
      xfer(7'h6C, 8'hA9, 1'h0, 16, 1'h0);
      xfer(`ADDR_CONFIG, 8'h04, 1'h0, 16, 1'h0);
      xfer(`ADDR_SWITCH, 8'h33, 1'h0, 17, 1'h0);
      cmp8("switches", 8'h33, sw);
      cmp8("flags", 8'h00, fl);
      xfer(`ADDR_CONFIG, 8'h06, 1'h0, 16, 1'h0);
      done("count");
   endtask : t_count

   task automatic t_crc;
      logic [7:0] d;
      xfer(`ADDR_CONFIG, 8'h07, 1'h0, 16, 1'h0);
      xfer(`ADDR_SWITCH, 8'hC3, 1'h0, 24, 1'h0);
      cmp8("switches", 8'hC3, sw);
      rd(`ADDR_CONFIG, 24, d);
      cmp8("config rd", 8'h07, d);
      xfer(`ADDR_SWITCH, 8'h11, 1'h0, 24, 1'h1);
      cmp8("flags", 8'h01, fl);
      cmp8("switches", 8'hC3, sw);
      xfer(7'h6C, 8'hA9, 1'h0, 24, 1'h1);
      cmp8("flags", 8'h01, fl);
      xfer(7'h6C, 8'hA9, 1'h0, 24, 1'h0);
      cmp8("flags", 8'h00, fl);
      xfer(`ADDR_SWITCH, 8'h11, 1'h0, 16, 1'h0);
      cmp8("flags", 8'h02, fl);
      xfer(7'h6C, 8'hA9, 1'h0, 24, 1'h0);
      done("crc");
   endtask : t_crc

   task automatic t_burst;
      xfer(`ADDR_BURST, 8'h01, 1'h0, 24, 1'h0);
      send({24'h0, c24(`ADDR_SWITCH, 8'h99),
         c24(`ADDR_SWITCH, 8'h66) ^ 24'h000001}, 48);
      cmp8("switches", 8'h99, sw);
      cmp8("flags", 8'h01, fl);
      xfer(7'h6C, 8'hA9, 1'h0, 24, 1'h0);
      cmp8("flags", 8'h00, fl);
      send({c24(`ADDR_SWITCH, 8'hA5), c24(`ADDR_SWITCH, 8'h5A),
         c24(`ADDR_CONFIG, 8'h06)}, 72);
      cmp8("switches", 8'h5A, sw);
      cmp8("flags", 8'h00, fl);
      send({40'h0, 1'h0, `ADDR_SWITCH, 8'h0F, 1'h0, `ADDR_SWITCH, 8'hF0},
         32);
      cmp8("switches", 8'hF0, sw);
      cmp8("flags", 8'h00, fl);
      send({32'h0, 1'h0, `ADDR_SWITCH, 8'h3C, 1'h0, `ADDR_SWITCH, 8'h00,
         8'h00}, 40);
      cmp8("flags", 8'h02, fl);
      // Key pair in two frames, so the reset burst bit cannot judge them
      xfer(`ADDR_SWRESET, 8'hA3, 1'h0, 16, 1'h0);
      xfer(`ADDR_SWRESET, 8'h05, 1'h0, 16, 1'h0);
      cmp8("switches", 8'h00, sw);
      cmp8("flags", 8'h00, fl);
      done("burst");
   endtask : t_burst

   task automatic t_defaults;
      logic [7:0] d;
      rd(`ADDR_CONFIG, 16, d);
      cmp8("config rd", 8'h06, d);
      rd(`ADDR_BURST, 16, d);
      cmp8("burst rd", 8'h00, d);
      done("defaults");
   endtask : t_defaults

   // ----------------------------------------------------------------
   // Run control
   // ----------------------------------------------------------------
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : tally_and_finish

   initial
   begin
      repeat (12) @(posedge clock);
      rst <= 1'h0;
      repeat (6) @(posedge clock);
      t_reset();
      t_regs();
      t_addr();
      t_count();
      t_crc();
      t_burst();
      t_defaults();
      tally_and_finish();
   end

   initial
   begin
      repeat (20000) @(posedge clock);
      errors++;
      tally_and_finish();
   end
endmodule : tb_spi_switch_register_bank
